// ---- sbc_regs.vh ----
`ifndef SBC_REGS_VH
`define SBC_REGS_VH
// sdram command encodings {cs_n, ras_n, cas_n, we_n}
`define SBC_CMD_NOP        4'h7
`define SBC_CMD_ACTIVE     4'h3
`define SBC_CMD_READ       4'h5
`define SBC_CMD_WRITE      4'h4
`define SBC_CMD_BURST_STOP 4'h6
`define SBC_CMD_PRECHARGE  4'h2
`define SBC_CMD_REFRESH    4'h1
`define SBC_CMD_LOAD_MODE  4'h0
`define SBC_CMD_DESELECT   4'hf
// mode register fields
`define SBC_MODE_WB        1'h0
`define SBC_MODE_CAS_LAT   3'h2
`define SBC_MODE_BTYPE     1'h0
`define SBC_MODE_BLEN      3'h7
// address bit 10 selects all banks on precharge
`define SBC_A10_BIT        10
// latency codes presented to the target core
`define SBC_LAT_READ       3'h3
`define SBC_LAT_WRITE      3'h0
// timing in ns, as printed
`define SBC_T_POWERUP_NS   100000
`define SBC_T_REFRESH_NS   15600
`define SBC_CLK_PERIOD_NS  25
// least wait rounds up, refresh interval rounds down
`define SBC_POWERUP_CYC    ((`SBC_T_POWERUP_NS + `SBC_CLK_PERIOD_NS - 1) / `SBC_CLK_PERIOD_NS)
`define SBC_REFRESH_CYC    (`SBC_T_REFRESH_NS / `SBC_CLK_PERIOD_NS)
// gap cycles after the init precharge, each refresh and mode load
`define SBC_GAP_CYC        17'h08
`define SBC_FULL_PAGE      256
`endif

// ---- sbc_fifo.v ----
`timescale 1ns/1ps
module sbc_fifo #(
    parameter WIDTH = 32,
    parameter DEPTH = 32,
    parameter AW    = 5
) (
    // clock and reset
    input  wire             sys_clk,
    input  wire             arst_n,
    // fill side
    input  wire             in_valid,
    output wire             in_ready,
    input  wire [WIDTH-1:0] in_data,
    // drain side
    output wire             out_valid,
    input  wire             out_ready,
    output wire [WIDTH-1:0] out_data
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0]    wr_ptr;
    reg [AW-1:0]    rd_ptr;
    reg [AW:0]      count;
    wire            push;
    wire            pop;

    assign in_ready  = (count != DEPTH[AW:0]);
    assign out_valid = (count != {(AW+1){1'b0}});
    assign out_data  = mem[rd_ptr];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always @(posedge sys_clk)
    begin
        if (push)
            mem[wr_ptr] <= in_data;
    end

    always @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            wr_ptr <= {AW{1'b0}};
            rd_ptr <= {AW{1'b0}};
            count  <= {(AW+1){1'b0}};
        end
        else
        begin
            if (push)
                wr_ptr <= (wr_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr + 1'b1;
            if (pop)
                rd_ptr <= (rd_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr + 1'b1;
            if (push && !pop)
                count <= count + 1'b1;
            else if (pop && !push)
                count <= count - 1'b1;
        end
    end
endmodule

// ---- sbc_ctrl.v ----
// What this block does
// - wait 100 us before any command
// - present nop throughout power-up wait
// - precharge all banks after wait
// - then exactly two auto refreshes
// - then load mode register, init done
// - mode selects cas latency two, 010
// - full page, sequential, programmed write bursts
// - begin+read flag starts read until end
// - begin+write flag starts write until end
// - auto refresh every 15.6 us
// - ready rises cycle after begin pulse; a begin while refresh is due is dropped
// - read latency code 011, data three later
// - write latency code 000, data coincident
// - end pulse stops burst, precharges all
// - clock enable follows initiator ready in bursts
// - async active-low reset restarts initialization
// - 12-bit muxed address plus bank bit
// - address advances first, data after latency
// - accept two words after write ready drops
`timescale 1ns/1ps
`include "sbc_regs.vh"
module sbc_ctrl #(
    parameter memory_index_width = 20,
    parameter DATA_WIDTH         = 32,
    parameter FIFO_DEPTH         = 32,
    parameter FIFO_AW            = 5,
    parameter POWERUP_CYC        = `SBC_POWERUP_CYC,
    parameter REFRESH_CYC        = `SBC_REFRESH_CYC
) (
    // clock and reset
    input  wire                          sys_clk,
    input  wire                          arst_n,
    // target core back-end
    input  wire                          memspace_cycle,
    input  wire                          read_txn_flag,
    input  wire                          write_txn_flag,
    input  wire [memory_index_width-1:0] mem_index,
    input  wire                          transfer_begin_pulse,
    input  wire                          transfer_end_pulse,
    input  wire                          read_go_strobe,
    input  wire                          write_go_strobe,
    input  wire                          initiator_ready_n,
    output wire                          read_side_ready,
    output wire                          write_side_ready,
    output wire [2:0]                    data_latency_count,
    // write data from the target core
    input  wire [DATA_WIDTH-1:0]         wr_data,
    // sdram pins
    output wire                          mem_chip_select_n,
    output wire                          row_strobe_n,
    output wire                          column_strobe_n,
    output wire                          mem_write_strobe_n,
    output reg                           mem_byte_mask,
    output reg  [11:0]                   mem_addr_mux,
    output reg                           mem_bank,
    output reg                           mem_clock_enable,
    output wire [DATA_WIDTH-1:0]         mem_dq_out,
    output reg                           mem_dq_oe,
    // status
    output wire                          init_done
);
    localparam ST_PWRUP = 10'h001;
    localparam ST_PRE0  = 10'h002;
    localparam ST_REF   = 10'h004;
    localparam ST_MODE  = 10'h008;
    localparam ST_IDLE  = 10'h010;
    localparam ST_ACT   = 10'h020;
    localparam ST_RD    = 10'h040;
    localparam ST_WR    = 10'h080;
    localparam ST_STOP  = 10'h100;
    localparam ST_ARF   = 10'h200;

    reg  [9:0]  state;
    reg  [9:0]  next_state;
    reg  [16:0] wait_cnt;
    reg  [16:0] next_wait_cnt;
    reg  [15:0] ref_cnt;
    reg         ref_due;
    reg  [1:0]  ref_left;
    reg  [1:0]  next_ref_left;
    reg  [3:0]  cmd;
    reg  [3:0]  next_cmd;
    reg         is_read;
    reg         done_seen;
    reg  [memory_index_width-1:0] latched_index;
    reg         inited;
    wire        gap_over;
    wire        ref_served;
    wire        fifo_in_ready;
    wire        fifo_out_valid;
    wire        in_burst;
    wire        wr_push;
    wire        wr_pop;
    reg  [FIFO_AW:0] fill;

    // row is the high part of the index, column the low byte
    function [11:0] row_of;
        input [memory_index_width-1:0] idx;
        reg   [31:0] wide;
        begin
            wide   = 32'h0;
            wide[memory_index_width-1:0] = idx;
            row_of = wide[20:9];
        end
    endfunction

    assign {mem_chip_select_n, row_strobe_n, column_strobe_n, mem_write_strobe_n} = cmd;
    assign gap_over   = (wait_cnt == 17'h0);
    assign in_burst   = state[6] || state[7];
    assign init_done  = inited;
    assign ref_served = state[9] && gap_over;
    assign read_side_ready  = (state[5] || state[6]) && is_read && !done_seen;
    // ready drops early enough that two more words still fit the fifo
    assign write_side_ready = (state[5] || state[7]) && !is_read && !done_seen
                              && (fill < FIFO_DEPTH[FIFO_AW:0] - 2'h2);
    // words are taken from activation on, else the first write never leaves the bank open
    assign wr_push = write_go_strobe && !is_read && (state[5] || state[7]) && fifo_in_ready;
    assign wr_pop  = fifo_out_valid && state[7] && !initiator_ready_n;
    assign data_latency_count = is_read ? `SBC_LAT_READ : `SBC_LAT_WRITE;

    // write data buffer: strobed words are taken as valid when they arrive
    sbc_fifo #(
        .WIDTH (DATA_WIDTH),
        .DEPTH (FIFO_DEPTH),
        .AW    (FIFO_AW)
    ) u_wr_fifo (
        .sys_clk   (sys_clk),
        .arst_n    (arst_n),
        .in_valid  (write_go_strobe && !is_read && (state[5] || state[7])),
        .in_ready  (fifo_in_ready),
        .in_data   (wr_data),
        .out_valid (fifo_out_valid),
        .out_ready (state[7] && !initiator_ready_n),
        .out_data  (mem_dq_out)
    );

    always @*
    begin
        next_state    = state;
        next_wait_cnt = gap_over ? 17'h0 : wait_cnt - 17'h1;
        next_ref_left = ref_left;
        next_cmd      = `SBC_CMD_NOP;
        case (state)
            ST_PWRUP:
                if (gap_over)
                begin
                    next_state = ST_PRE0;
                    next_cmd   = `SBC_CMD_PRECHARGE;
                    next_wait_cnt = `SBC_GAP_CYC;
                end
            ST_PRE0:
                if (gap_over)
                begin
                    next_state    = ST_REF;
                    next_cmd      = `SBC_CMD_REFRESH;
                    next_ref_left = 2'h1;
                    next_wait_cnt = `SBC_GAP_CYC;
                end
            ST_REF:
                if (gap_over)
                begin
                    if (ref_left != 2'h0)
                    begin
                        next_cmd      = `SBC_CMD_REFRESH;
                        next_ref_left = ref_left - 2'h1;
                    end
                    else
                    begin
                        next_state = ST_MODE;
                        next_cmd   = `SBC_CMD_LOAD_MODE;
                    end
                    next_wait_cnt = `SBC_GAP_CYC;
                end
            ST_MODE:
                if (gap_over)
                    next_state = ST_IDLE;
            ST_IDLE:
                if (ref_due)
                begin
                    next_state    = ST_ARF;
                    next_cmd      = `SBC_CMD_REFRESH;
                    next_wait_cnt = `SBC_GAP_CYC;
                end
                else if (transfer_begin_pulse && memspace_cycle
                         && (read_txn_flag || write_txn_flag))
                begin
                    next_state = ST_ACT;
                    next_cmd   = `SBC_CMD_ACTIVE;
                end
            ST_ACT:
                if (done_seen || transfer_end_pulse)
                    next_state = ST_STOP;
                else if (is_read && read_go_strobe)
                begin
                    next_state = ST_RD;
                    next_cmd   = `SBC_CMD_READ;
                end
                else if (!is_read && fifo_out_valid)
                begin
                    next_state = ST_WR;
                    next_cmd   = `SBC_CMD_WRITE;
                end
            ST_RD, ST_WR:
                if (transfer_end_pulse || (done_seen && !fifo_out_valid))
                begin
                    next_state    = ST_STOP;
                    next_cmd      = `SBC_CMD_BURST_STOP;
                end
            ST_STOP:
            begin
                next_state    = ST_IDLE;
                next_cmd      = `SBC_CMD_PRECHARGE;
                next_wait_cnt = 17'h2;
            end
            ST_ARF:
                if (gap_over)
                    next_state = ST_IDLE;
            default:
                next_state = ST_PWRUP;
        endcase
    end

    always @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            state     <= ST_PWRUP;
            wait_cnt  <= POWERUP_CYC[16:0];
            fill      <= {(FIFO_AW+1){1'b0}};
            ref_left  <= 2'h0;
            cmd       <= `SBC_CMD_NOP;
            ref_cnt   <= 16'h0;
            ref_due   <= 1'b0;
            is_read   <= 1'b0;
            done_seen <= 1'b0;
            inited    <= 1'b0;
            latched_index <= {memory_index_width{1'b0}};
        end
        else
        begin
            state    <= next_state;
            wait_cnt <= (state[4] && next_state[4]) ? 17'h0 : next_wait_cnt;
            ref_left <= next_ref_left;
            cmd      <= next_cmd;
            if (wr_push && !wr_pop)
                fill <= fill + 1'b1;
            else if (wr_pop && !wr_push)
                fill <= fill - 1'b1;
            if (state[3] && gap_over)
                inited <= 1'b1;
            if (ref_cnt == REFRESH_CYC[15:0] - 16'h1)
                ref_cnt <= 16'h0;
            else
                ref_cnt <= ref_cnt + 16'h1;
            // a new tick wins over the clear of a served refresh
            if (inited && ref_cnt == REFRESH_CYC[15:0] - 16'h1)
                ref_due <= 1'b1;
            else if (ref_served)
                ref_due <= 1'b0;
            if (state[4] && transfer_begin_pulse && !ref_due)
            begin
                is_read       <= read_txn_flag;
                latched_index <= mem_index;
                done_seen     <= 1'b0;
            end
            else if ((state[5] || in_burst) && transfer_end_pulse)
                done_seen <= 1'b1;
        end
    end

    // address, bank, mask and clock enable follow the command issued
    always @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            mem_addr_mux     <= 12'h0;
            mem_bank         <= 1'b0;
            mem_byte_mask    <= 1'b1;
            mem_clock_enable <= 1'b1;
            mem_dq_oe        <= 1'b0;
        end
        else
        begin
            mem_addr_mux  <= 12'h0;
            mem_byte_mask <= 1'b0;
            mem_dq_oe     <= next_state[7];
            case (next_cmd)
                `SBC_CMD_PRECHARGE:
                    mem_addr_mux[`SBC_A10_BIT] <= 1'b1;
                `SBC_CMD_LOAD_MODE:
                    mem_addr_mux <= {2'h0, `SBC_MODE_WB, 2'h0, `SBC_MODE_CAS_LAT,
                                     `SBC_MODE_BTYPE, `SBC_MODE_BLEN};
                `SBC_CMD_ACTIVE:
                begin
                    mem_addr_mux <= row_of(mem_index);
                    mem_bank     <= mem_index[8];
                end
                `SBC_CMD_READ, `SBC_CMD_WRITE:
                    mem_addr_mux <= {4'h0, latched_index[7:0]};
                default:
                    mem_addr_mux <= 12'h0;
            endcase
            // stalls the device while the bus master inserts waits
            if (next_state[6] || next_state[7])
                mem_clock_enable <= !initiator_ready_n;
            else
                mem_clock_enable <= 1'b1;
        end
    end
endmodule

// ---- sbc_ctrl_props.sv ----
`timescale 1ns/1ps
`include "sbc_regs.vh"
module sbc_ctrl_props #(
    parameter POWERUP_CYC = `SBC_POWERUP_CYC,
    parameter REFRESH_CYC = `SBC_REFRESH_CYC
) (
    // clock and reset
    input wire        sys_clk,
    input wire        arst_n,
    // back-end side
    input wire        memspace_cycle,
    input wire        read_txn_flag,
    input wire        transfer_begin_pulse,
    input wire        transfer_end_pulse,
    input wire        initiator_ready_n,
    input wire        read_side_ready,
    input wire        write_side_ready,
    input wire [2:0]  data_latency_count,
    input wire        init_done,
    // sdram pins
    input wire        mem_chip_select_n,
    input wire        row_strobe_n,
    input wire        column_strobe_n,
    input wire        mem_write_strobe_n,
    input wire [11:0] mem_addr_mux,
    input wire        mem_clock_enable
);
    wire [3:0]  cmd = {mem_chip_select_n, row_strobe_n, column_strobe_n, mem_write_strobe_n};
    wire        busy = read_side_ready | write_side_ready;
    reg  [15:0] cyc;
    reg  [15:0] since_ref;
    reg  [1:0]  init_refs;
    reg         seen;
    reg         burst;
    always @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            cyc       <= 16'h0000;
            since_ref <= 16'h0000;
            init_refs <= 2'h0;
            seen      <= 1'b0;
            burst     <= 1'b0;
        end
        else
        begin
            cyc       <= (cyc == 16'hffff) ? cyc : cyc + 16'h0001;
            since_ref <= (cmd == `SBC_CMD_REFRESH) ? 16'h0000 : since_ref + 16'h0001;
            seen      <= seen | (cmd != `SBC_CMD_NOP);
            // clock enable tracks the master only once a burst command is out
            if (cmd == `SBC_CMD_READ || cmd == `SBC_CMD_WRITE)
                burst <= 1'b1;
            else if (cmd == `SBC_CMD_BURST_STOP || cmd == `SBC_CMD_PRECHARGE)
                burst <= 1'b0;
            if (cmd == `SBC_CMD_REFRESH && init_refs != 2'h3)
                init_refs <= init_refs + 2'h1;
        end
    end
    default clocking dc @(posedge sys_clk); endclocking
    default disable iff (!arst_n);
    a_powerup_nop: assert property (cyc < POWERUP_CYC - 1 |-> cmd == `SBC_CMD_NOP)
        else $error("command during power-up wait");
    a_first_precharge: assert property (!seen && cmd != `SBC_CMD_NOP |->
        cmd == `SBC_CMD_PRECHARGE && mem_addr_mux[`SBC_A10_BIT]) else $error("bad first command");
    a_two_refreshes: assert property (cmd == `SBC_CMD_LOAD_MODE |-> init_refs == 2'h2)
        else $error("mode load without two refreshes");
    a_mode_value: assert property (cmd == `SBC_CMD_LOAD_MODE |-> mem_addr_mux == 12'h027)
        else $error("wrong mode value");
    a_read_ready_cause: assert property ($rose(read_side_ready) |->
        $past(transfer_begin_pulse) && $past(read_txn_flag) && $past(memspace_cycle))
        else $error("read ready without begin");
    a_active_ready: assert property (cmd == `SBC_CMD_ACTIVE |-> busy && $past(transfer_begin_pulse))
        else $error("activate without ready or begin");
    a_read_latency: assert property (read_side_ready |-> data_latency_count == 3'h3)
        else $error("read latency code wrong");
    a_write_latency: assert property (write_side_ready |-> data_latency_count == 3'h0)
        else $error("write latency code wrong");
    a_end_precharge: assert property (transfer_end_pulse && busy |-> ##[1:8]
        (cmd == `SBC_CMD_PRECHARGE && mem_addr_mux[`SBC_A10_BIT])) else $error("no precharge after end");
    a_cke_follows: assert property (burst && busy && $past(busy) |->
        mem_clock_enable == !$past(initiator_ready_n)) else $error("clock enable not following");
    a_refresh_gap: assert property (init_done |-> since_ref < REFRESH_CYC + 120)
        else $error("refresh overdue");
    c_read: cover property (cmd == `SBC_CMD_READ);
    c_write: cover property (cmd == `SBC_CMD_WRITE);
    c_refresh: cover property (init_done && cmd == `SBC_CMD_REFRESH);
endmodule
bind sbc_ctrl sbc_ctrl_props #(.POWERUP_CYC(POWERUP_CYC), .REFRESH_CYC(REFRESH_CYC))
    sbc_ctrl_props_inst (.sys_clk(sys_clk), .arst_n(arst_n), .memspace_cycle(memspace_cycle),
    .read_txn_flag(read_txn_flag), .transfer_begin_pulse(transfer_begin_pulse),
    .transfer_end_pulse(transfer_end_pulse), .initiator_ready_n(initiator_ready_n),
    .read_side_ready(read_side_ready), .write_side_ready(write_side_ready),
    .data_latency_count(data_latency_count), .init_done(init_done),
    .mem_chip_select_n(mem_chip_select_n), .row_strobe_n(row_strobe_n),
    .column_strobe_n(column_strobe_n), .mem_write_strobe_n(mem_write_strobe_n),
    .mem_addr_mux(mem_addr_mux), .mem_clock_enable(mem_clock_enable));

// ---- sbc_sdram_model.sv ----
`timescale 1ns/1ps
`include "sbc_regs.vh"
module sbc_sdram_model (
    // clock and reset
    input  wire        sys_clk,
    input  wire        arst_n,
    // sdram pins
    input  wire [3:0]  cmd,
    input  wire [11:0] addr,
    input  wire        bank,
    input  wire [31:0] dq,
    // what the device saw
    output reg  [11:0] mode,
    output reg  [11:0] row,
    output reg  [11:0] col,
    output reg         col_bank,
    output reg  [31:0] first_dq,
    output reg  [7:0]  refreshes,
    output reg  [7:0]  faults
);
    reg  open_row;
    wire access = (cmd == `SBC_CMD_READ) || (cmd == `SBC_CMD_WRITE);
    // a bank state clash means the strobes broke the command table
    wire clash = open_row ? (cmd == `SBC_CMD_ACTIVE || cmd == `SBC_CMD_REFRESH ||
                             cmd == `SBC_CMD_LOAD_MODE) : access;
    always @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            open_row  <= 1'b0;
            refreshes <= 8'h00;
            faults    <= 8'h00;
            mode      <= 12'h000;
        end
        else
        begin
            open_row  <= (cmd == `SBC_CMD_ACTIVE) | (open_row & (cmd != `SBC_CMD_PRECHARGE));
            faults    <= faults + {7'h00, clash};
            refreshes <= refreshes + {7'h00, cmd == `SBC_CMD_REFRESH};
            if (cmd == `SBC_CMD_LOAD_MODE)
                mode <= addr;
        end
    end
    always @(posedge sys_clk)
    begin
        if (cmd == `SBC_CMD_ACTIVE)
            row <= addr;
        if (access)
            col <= addr;
        if (access)
            col_bank <= bank;
        if (cmd == `SBC_CMD_WRITE)
            first_dq <= dq;
    end
endmodule

// ---- testbench.sv ----
`timescale 1ns/1ps
`include "sbc_regs.vh"
module testbench;
    localparam RF = 60;
    localparam [19:0] IDX = {11'h2b3, 1'b1, 8'h5a};
    reg         sys_clk, arst_n, memspace_cycle, read_txn_flag, write_txn_flag;
    reg         transfer_begin_pulse, transfer_end_pulse, read_go_strobe, write_go_strobe;
    reg         initiator_ready_n;
    reg  [19:0] mem_index;
    reg  [31:0] wr_data;
    wire        read_side_ready, write_side_ready, init_done, mem_bank, cke, col_bank, oe, dqm;
    wire [2:0]  data_latency_count;
    wire [3:0]  cmd;
    wire [11:0] mem_addr_mux, mode, row, col;
    wire [31:0] mem_dq_out, first_dq;
    wire [7:0]  refreshes, faults;
    integer     errors, compares, i, j;
    sbc_ctrl #(.POWERUP_CYC(40), .REFRESH_CYC(RF)) sbc_ctrl_inst (.sys_clk(sys_clk),
        .arst_n(arst_n), .memspace_cycle(memspace_cycle), .read_txn_flag(read_txn_flag),
        .write_txn_flag(write_txn_flag), .mem_index(mem_index),
        .transfer_begin_pulse(transfer_begin_pulse), .transfer_end_pulse(transfer_end_pulse),
        .read_go_strobe(read_go_strobe), .write_go_strobe(write_go_strobe),
        .initiator_ready_n(initiator_ready_n), .read_side_ready(read_side_ready),
        .write_side_ready(write_side_ready), .data_latency_count(data_latency_count),
        .wr_data(wr_data), .mem_chip_select_n(cmd[3]), .row_strobe_n(cmd[2]),
        .column_strobe_n(cmd[1]), .mem_write_strobe_n(cmd[0]), .mem_byte_mask(dqm),
        .mem_addr_mux(mem_addr_mux), .mem_bank(mem_bank), .mem_clock_enable(cke),
        .mem_dq_out(mem_dq_out), .mem_dq_oe(oe), .init_done(init_done));
    sbc_sdram_model sbc_sdram_model_inst (.sys_clk(sys_clk), .arst_n(arst_n), .cmd(cmd),
        .addr(mem_addr_mux), .bank(mem_bank), .dq(mem_dq_out), .mode(mode), .row(row),
        .col(col), .col_bank(col_bank), .first_dq(first_dq), .refreshes(refreshes),
        .faults(faults));
    task end_sim;
    begin
        $display("errors=%0d compares=%0d", errors, compares);
        if (errors == 0 && compares > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    end
    endtask
    task check(input [31:0] seen, input [31:0] exp);
    begin
        compares = compares + 1;
        if (seen !== exp)
        begin
            errors = errors + 1;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    end
    endtask
    task t_init;
    begin
        for (j = 0; j < 300 && !init_done; j = j + 1)
            @(posedge sys_clk);
        @(negedge sys_clk);
        check(init_done, 1'b1);
        check(refreshes, 8'h02);
        check(mode, 12'h027);
        check(faults, 8'h00);
    end
    endtask
    // begin just after a refresh so no refresh is due when the request lands
    task start(input rd);
        reg [7:0] r;
    begin
        r = refreshes;
        for (j = 0; j < 3 * RF && refreshes == r; j = j + 1)
            @(posedge sys_clk);
        repeat (14) @(posedge sys_clk);
        memspace_cycle <= 1'b1;
        read_txn_flag <= rd;
        write_txn_flag <= !rd;
        mem_index <= IDX;
        transfer_begin_pulse <= 1'b1;
        @(posedge sys_clk);
        transfer_begin_pulse <= 1'b0;
        @(negedge sys_clk);
        check(rd ? read_side_ready : write_side_ready, 1'b1);
        check(data_latency_count, rd ? 3'h3 : 3'h0);
    end
    endtask
    task beats(input rd, input integer n);
    begin
        for (i = 0; i < n; i = i + 1)
        begin
            @(posedge sys_clk);
            read_go_strobe <= rd;
            write_go_strobe <= !rd;
            wr_data <= 32'hc0de_0000 + i;
        end
        @(posedge sys_clk);
        read_go_strobe <= 1'b0;
        write_go_strobe <= 1'b0;
    end
    endtask
    task finish;
    begin
        @(posedge sys_clk);
        transfer_end_pulse <= 1'b1;
        @(posedge sys_clk);
        transfer_end_pulse <= 1'b0;
        repeat (12) @(posedge sys_clk);
        check(faults, 8'h00);
    end
    endtask
    task t_bursts;
    begin
        start(1'b1);
        beats(1'b1, 6);
        finish;
        check({row, col[7:0], col_bank}, {12'h2b3, 8'h5a, 1'b1});
        start(1'b0);
        beats(1'b0, 3);
        initiator_ready_n <= 1'b1;
        repeat (2) @(posedge sys_clk);
        @(negedge sys_clk);
        check(cke, 1'b0);
        check({oe, dqm}, 2'h2);
        beats(1'b0, 0);
        initiator_ready_n <= 1'b0;
        beats(1'b0, 3);
        finish;
        check(first_dq, 32'hc0de_0000);
    end
    endtask
    // stalled master keeps the buffer from draining until it refuses
    task t_fill;
    begin
        start(1'b0);
        @(posedge sys_clk);
        initiator_ready_n <= 1'b1;
        for (i = 0; i < 40 && write_side_ready; i = i + 1)
        begin
            @(posedge sys_clk);
            write_go_strobe <= 1'b1;
            wr_data <= i;
            @(negedge sys_clk);
        end
        repeat (2) @(posedge sys_clk);
        write_go_strobe <= 1'b0;
        @(negedge sys_clk);
        check(write_side_ready, 1'b0);
        @(posedge sys_clk);
        initiator_ready_n <= 1'b0;
        for (j = 0; j < 80 && !write_side_ready; j = j + 1)
            @(negedge sys_clk);
        check(write_side_ready, 1'b1);
        finish;
    end
    endtask
    task t_reset;
        reg [7:0] r0;
    begin
        r0 = refreshes;
        repeat (3 * RF + 30) @(posedge sys_clk);
        check(refreshes - r0 >= 8'h03, 1'b1);
        start(1'b1);
        beats(1'b1, 2);
        arst_n <= 1'b0;
        @(negedge sys_clk);
        check({read_side_ready, init_done, oe, dqm, cmd}, {4'h1, `SBC_CMD_NOP});
        @(posedge sys_clk);
        arst_n <= 1'b1;
        t_init;
    end
    endtask
    initial
    begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end
    initial
    begin
        repeat (10000) @(posedge sys_clk);
        errors = errors + 1;
        end_sim;
    end
    initial
    begin
        errors = 0;
        compares = 0;
        {arst_n, memspace_cycle, read_txn_flag, write_txn_flag} = 4'h0;
        {transfer_begin_pulse, transfer_end_pulse, read_go_strobe, write_go_strobe} = 4'h0;
        initiator_ready_n = 1'b0;
        mem_index = 20'h00000;
        wr_data = 32'h0000_0000;
        repeat (4) @(posedge sys_clk);
        arst_n <= 1'b1;
        t_init;
        t_bursts;
        t_fill;
        t_reset;
        end_sim;
    end
endmodule
